// file: bench/sac_host_model.sv
/* Host controller driving the serial and parallel control pins.
 Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ns
module sac_host_model (
   output logic serialClock,
   output logic serialData,
   output logic latchStrobe,
   output logic modeSelect,
   output logic [6:0] parallelCtrl
);
   initial begin
      serialClock = 1'b0;
      serialData = 1'b0;
      latchStrobe = 1'b0;
      modeSelect = 1'b1;
      parallelCtrl = 7'h00;
   end
   task pins(input logic m, input logic [6:0] p, input logic s);
      modeSelect = m;
      parallelCtrl = m ? 7'h00 : p;
      latchStrobe = s;
      #800;
   endtask
   // Link clock only runs inside a frame
   task frame(input logic [15:0] f, input logic endHigh);
      #7 latchStrobe = 1'b0;
      for (int i = 0; i < 16; i++) begin
         serialData = f[i];
         #62 serialClock = 1'b1;
         #63 serialClock = (i == 15) ? endHigh : 1'b0;
      end
      serialData = ~f[15];
      #100 latchStrobe = 1'b1;
      #250 latchStrobe = 1'b0;
      serialClock = 1'b0;
      #500;
   endtask
endmodule

// file: bench/sac_top_assertions.sv
/* Concurrent checks on the attenuator control port pins.
 Assumes binding to sac_top and the reset settle count of four. */
`timescale 1ns/1ns
module sac_top_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic latchStrobe,
   input wire logic modeSelect,
   input wire logic [6:0] parallelCtrl,
   input wire sac_pkg::sac_atten_t coreState
);
   logic seenStrobe;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) seenStrobe <= 1'b0;
      else if (latchStrobe) seenStrobe <= 1'b1;
   end
   a_reset_max: assert property ($fell(sys_rst) |-> coreState == 7'h7f)
      else $error("state not maximum after reset");
   a_max_until_latch: assert property (!seenStrobe |-> coreState == 7'h7f)
      else $error("state left maximum before any strobe");
   a_hold_strobe_low: assert property ((!latchStrobe)[*8] |-> $stable(coreState))
      else $error("state moved while strobe low");
   a_direct_follow: assert property ((!modeSelect && latchStrobe && $stable(parallelCtrl))[*8] |->
      ##4 (coreState == $past(parallelCtrl, 4))) else $error("state not following lines");
   a_no_dip: assert property (!$stable(coreState) |->
      ((coreState | $past(coreState)) == coreState) || ((coreState & $past(coreState)) == coreState))
      else $error("state step drops and adds bits at once");
   a_bridge_hold: assert property (!$stable(coreState) |=> $stable(coreState)[*3])
      else $error("state step too short");
   a_unmapped_error: assert property (psel && penable && paddr[11:4] != 8'h00 |-> pslverr)
      else $error("no error on unmapped access");
   a_mapped_ok: assert property (psel && penable && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped access");
endmodule
bind sac_top sac_top_checker u_chk (.clk, .sys_rst, .psel, .penable, .paddr, .pslverr, .latchStrobe,
   .modeSelect, .parallelCtrl, .coreState);

// file: bench/step_attenuator_control_port_bench.sv
/* Self-checking bench for the attenuator control port.
 Assumes the host model for pins and an APB master here. */
`timescale 1ns/1ns
module step_attenuator_control_port_bench;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic serialClock, serialData, latchStrobe, modeSelect;
   logic [6:0] parallelCtrl;
   logic [2:0] addrStrap;
   sac_pkg::sac_atten_t coreState;
   int errCount = 0;
   int numChecks = 0;
   int cycles = 0;
   sac_top DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .serialClock, .serialData, .latchStrobe, .modeSelect, .parallelCtrl, .addrStrap, .coreState);
   sac_host_model host (.serialClock, .serialData, .latchStrobe, .modeSelect, .parallelCtrl);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task reportAndStop();
      if (errCount == 0 && numChecks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errCount++;
         reportAndStop();
      end
   end
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      numChecks++;
      if (g !== x) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, x, rdv);
   endtask
   task coreIs(input logic [6:0] x);
      chk("coreState", {25'h0, x}, {25'h0, coreState});
   endtask
   initial begin
      sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; addrStrap = 3'h3;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      coreIs(7'h7f);
      repeat (3) @(posedge clk);
      rd(12'h000, 32'h0000077f, "status");
      rd(12'h004, 32'h00000004, "config");
      apb(1'b1, 12'h004, 32'h00000105);
      rd(12'h004, 32'h00000105, "config");
      apb(1'b1, 12'h004, 32'h00000004);
      apb(1'b0, 12'h010, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      host.frame(16'hab49, 1'b0);
      coreIs(7'h49);
      rd(12'h008, 32'h0000ab49, "frame");
      for (int s = 0; s < 8; s++) begin
         @(posedge clk);
         addrStrap <= s[2:0];
         host.frame({5'h15, s[2:0], 8'(s * 9 + 1)}, 1'b0);
         coreIs(7'(s * 9 + 1));
      end
      host.frame(16'h0611, 1'b0);
      coreIs(7'd64);
      host.frame(16'hf722, 1'b1);
      coreIs(7'h22);
      rd(12'h00c, 32'h0001000a, "counts");
      apb(1'b1, 12'h00c, 32'h0);
      rd(12'h00c, 32'h00000000, "counts");
      apb(1'b1, 12'h004, 32'h00000105);
      host.frame(16'hf7a5, 1'b0);
      coreIs(7'h22);
      rd(12'h00c, 32'h00000001, "counts");
      apb(1'b1, 12'h004, 32'h00000000);
      host.frame(16'h0fb3, 1'b0);
      coreIs(7'h33);
      rd(12'h000, 32'h00000fb3, "status");
      apb(1'b1, 12'h004, 32'h00000004);
      host.frame(16'h0f11, 1'b0);
      coreIs(7'h11);
      host.pins(1'b0, 7'h55, 1'b1);
      host.pins(1'b0, 7'h55, 1'b0);
      coreIs(7'h55);
      host.pins(1'b0, 7'h2a, 1'b0);
      coreIs(7'h55);
      host.frame(16'h0711, 1'b0);
      coreIs(7'h2a);
      host.pins(1'b0, 7'h01, 1'b1);
      coreIs(7'h01);
      host.pins(1'b0, 7'h40, 1'b1);
      coreIs(7'h40);
      host.pins(1'b1, 7'h33, 1'b0);
      coreIs(7'h40);
      reportAndStop();
   end
endmodule

// file: inc/sac_defs.svh
/*
 Constants of the step attenuator control port: register offsets, field
 positions, reset values and frame layout.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// Register byte offsets on the APB
`define SAC_ADDR_STATUS 12'h000
`define SAC_ADDR_CONFIG 12'h004
`define SAC_ADDR_FRAME 12'h008
`define SAC_ADDR_COUNTS 12'h00c

// Serial frame layout
`define SAC_FRAME_BITS 16
`define SAC_ATTN_MSB 6
`define SAC_TOPBIT 7
`define SAC_ADDR_LSB 8
`define SAC_ADDR_MSB 10

// Status register fields
`define SAC_ST_TOPBIT 7
`define SAC_ST_MODE 8
`define SAC_ST_STRAP_LSB 9
`define SAC_ST_STRAP_MSB 11
`define SAC_ST_BRIDGE 12

// Config register fields
`define SAC_CFG_SETTLE_MSB 7
`define SAC_CFG_REJECT 8

// Reset values and count step
`define SAC_STATE_MAX 7'h7f
`define SAC_SETTLE_RST 8'h04
`define SAC_CNT_ONE 16'h0001

`endif

// file: inc/sac_pkg.sv
/*
 Types shared by the step attenuator control port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sac_pkg;

   typedef logic [6:0] sac_atten_t;

   typedef enum logic [0:0] {
      SAC_STEADY = 1'b0,
      SAC_BRIDGE = 1'b1
   } sac_step_t;

endpackage

// file: rtl/sac_top.sv
/*
 Control front end of a 7-bit step attenuator: parallel and serial
 addressable interfaces, a transition sequencer and an APB register window.
 Assumes clk at 20 MHz, serialClock from the host as its own domain, and
 serialData / latchStrobe launched by the host relative to serialClock.
*/
// Behaviour
// - modeSelect low parallel, high serial
// - Seven binary weighted lines set attenuation
// - Latched parallel captures on strobe pulse
// - Strobe held high makes lines transparent
// - 16-bit shift register behind transparent latch
// - Attenuation word first, address upper byte
// - Apply word only on strap address match
// - Shift only while latch strobe low
// - Strobe rise transfers frame, any clock level
// - Word is dB times four, top bit low
// - Only three low address bits compared
// - Sequence changes so attenuation never dips
// - Reset to maximum attenuation until programmed
`timescale 1ns/1ns
`include "sac_defs.svh"

module sac_top (
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host facing control pins
   input wire logic serialClock,
   input wire logic serialData,
   input wire logic latchStrobe,
   input wire logic modeSelect,
   input wire logic [6:0] parallelCtrl,
   input wire logic [2:0] addrStrap,
   // Drive to the attenuator core
   output sac_pkg::sac_atten_t coreState
);

   // Serial clock domain
   logic [`SAC_FRAME_BITS-1:0] shiftReg;

   // Synchronisers: first stage read only by the second
   logic leMeta;
   logic leSync;
   logic modeMeta;
   logic modeSync;
   logic [6:0] parMeta;
   logic [6:0] parSync;
   logic [2:0] strapMeta;
   logic [2:0] strapSync;
   logic leLast;
   logic leRise;
   // Frame copied into the clk domain once the strobe is seen high
   logic [`SAC_FRAME_BITS-1:0] frameSync;
   logic commitPending;

   // Latch and sequencer state
   sac_pkg::sac_atten_t targetState;
   sac_pkg::sac_atten_t next_target;
   logic targetTopBit;
   logic next_topBit;
   logic [`SAC_FRAME_BITS-1:0] frameHold;
   logic addrMatch;
   logic wordAccepted;
   sac_pkg::sac_step_t stepState;
   logic [7:0] settleCount;

   // Software visible
   logic [7:0] cfgSettle;
   logic cfgRejectTop;
   logic [15:0] matchCount;
   logic [15:0] missCount;

   // APB decode
   logic apbSetup;
   logic apbAccess;
   logic addrHit;
   logic cfgWrite;
   logic cntWrite;
   logic [31:0] next_rdata;

   // Shift register on the host's clock. A stopped clock between frames is
   // harmless: the contents only matter once the strobe has risen.
   always_ff @(posedge serialClock or posedge sys_rst) begin
      if (sys_rst) begin
         shiftReg <= '0;
      end else if (!latchStrobe) begin
         // New bit enters at the top, so the first bit lands in bit 0
         shiftReg <= {serialData, shiftReg[`SAC_FRAME_BITS-1:1]};
      end
   end

   // Pin synchronisers into the clk domain, one pair of stages per pin group
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         leMeta <= 1'b0;
         leSync <= 1'b0;
      end else begin
         leMeta <= latchStrobe;
         leSync <= leMeta;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         modeMeta <= 1'b0;
         modeSync <= 1'b0;
      end else begin
         modeMeta <= modeSelect;
         modeSync <= modeMeta;
      end
   end

   // Lines may skew bit against bit; the bridge absorbs a one cycle mix
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         parMeta <= '0;
         parSync <= '0;
      end else begin
         parMeta <= parallelCtrl;
         parSync <= parMeta;
      end
   end

   // Straps are static in use, but a board may still move them live
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strapMeta <= '0;
         strapSync <= '0;
      end else begin
         strapMeta <= addrStrap;
         strapSync <= strapMeta;
      end
   end

   // Strobe edge detect works on the synchronised level only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         leLast <= 1'b0;
      end else begin
         leLast <= leSync;
      end
   end

   assign leRise = leSync & ~leLast;

   // The shift register is frozen while the strobe is high, and the strobe
   // has been high for two clk edges before leRise, so the copy is quiet.
   // Limitation: the host must keep the strobe high for three clk periods.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frameSync <= '0;
      end else if (leRise) begin
         frameSync <= shiftReg;
      end
   end

   // Commit follows the copy by one edge so decode sees only settled bits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         commitPending <= 1'b0;
      end else begin
         commitPending <= leRise;
      end
   end

   assign addrMatch = frameSync[`SAC_ADDR_MSB:`SAC_ADDR_LSB] == strapSync;
   assign wordAccepted = addrMatch & ~(cfgRejectTop & frameSync[`SAC_TOPBIT]);

   // Selects where the next attenuation state comes from
   always_comb begin
      next_target = targetState;
      next_topBit = targetTopBit;
      if (!modeSync) begin
         // Transparent while high, holds the last value after the fall
         if (leSync) begin
            next_target = parSync;
         end
      end else if (commitPending && wordAccepted) begin
         next_target = frameSync[`SAC_ATTN_MSB:0];
         next_topBit = frameSync[`SAC_TOPBIT];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         targetState <= `SAC_STATE_MAX;
      end else begin
         targetState <= next_target;
      end
   end

   // Top bit is kept only for status; the reject option checks the top bit of frameSync
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         targetTopBit <= 1'b0;
      end else begin
         targetTopBit <= next_topBit;
      end
   end

   // Last frame seen on a strobe rise in serial mode, matched or not
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frameHold <= '0;
      end else if (commitPending && modeSync) begin
         frameHold <= frameSync;
      end
   end

   // Transition sequencer: bridge through the bitwise OR of old and new.
   // OR of two codes is never below either, so attenuation never drops
   // below both ends during the change; costs settle cycles of latency.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         coreState <= `SAC_STATE_MAX;
         stepState <= sac_pkg::SAC_STEADY;
         settleCount <= '0;
      end else begin
         unique case (stepState)
            sac_pkg::SAC_STEADY: begin
               if (targetState != coreState) begin
                  if (cfgSettle == '0) begin
                     coreState <= targetState;
                  end else begin
                     coreState <= coreState | targetState;
                     settleCount <= cfgSettle;
                     stepState <= sac_pkg::SAC_BRIDGE;
                  end
               end
            end
            sac_pkg::SAC_BRIDGE: begin
               // A target that moves mid bridge widens the bridge too
               coreState <= coreState | targetState;
               if (settleCount == 8'h01) begin
                  coreState <= targetState;
                  stepState <= sac_pkg::SAC_STEADY;
                  settleCount <= '0;
               end else begin
                  settleCount <= settleCount - 8'h01;
               end
            end
         endcase
      end
   end

   // APB decode, zero wait states
   assign apbSetup = psel & ~penable;
   assign apbAccess = psel & penable;
   assign addrHit = (paddr == `SAC_ADDR_STATUS) || (paddr == `SAC_ADDR_CONFIG) ||
                    (paddr == `SAC_ADDR_FRAME) || (paddr == `SAC_ADDR_COUNTS);
   assign cfgWrite = apbAccess & pwrite & (paddr == `SAC_ADDR_CONFIG);
   assign cntWrite = apbAccess & pwrite & (paddr == `SAC_ADDR_COUNTS);
   assign pready = 1'b1;
   assign pslverr = apbAccess & ~addrHit;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfgSettle <= `SAC_SETTLE_RST;
         cfgRejectTop <= 1'b0;
      end else if (cfgWrite) begin
         cfgSettle <= pwdata[`SAC_CFG_SETTLE_MSB:0];
         cfgRejectTop <= pwdata[`SAC_CFG_REJECT];
      end
   end

   // Address match statistics; a clear with a count event in one cycle leaves a count of one
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         matchCount <= '0;
      end else if (cntWrite) begin
         matchCount <= (commitPending && modeSync && addrMatch) ? `SAC_CNT_ONE : '0;
      end else if (commitPending && modeSync && addrMatch) begin
         matchCount <= matchCount + `SAC_CNT_ONE;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         missCount <= '0;
      end else if (cntWrite) begin
         missCount <= (commitPending && modeSync && !addrMatch) ? `SAC_CNT_ONE : '0;
      end else if (commitPending && modeSync && !addrMatch) begin
         missCount <= missCount + `SAC_CNT_ONE;
      end
   end

   // Read data is prepared in the setup phase so it stands in the access phase
   always_comb begin
      next_rdata = '0;
      unique case (paddr)
         `SAC_ADDR_STATUS: begin
            next_rdata[`SAC_ATTN_MSB:0] = coreState;
            next_rdata[`SAC_ST_TOPBIT] = targetTopBit;
            next_rdata[`SAC_ST_MODE] = modeSync;
            next_rdata[`SAC_ST_STRAP_MSB:`SAC_ST_STRAP_LSB] = strapSync;
            next_rdata[`SAC_ST_BRIDGE] = stepState == sac_pkg::SAC_BRIDGE;
         end
         `SAC_ADDR_CONFIG: begin
            next_rdata[`SAC_CFG_SETTLE_MSB:0] = cfgSettle;
            next_rdata[`SAC_CFG_REJECT] = cfgRejectTop;
         end
         `SAC_ADDR_FRAME: begin
            next_rdata[`SAC_FRAME_BITS-1:0] = frameHold;
         end
         `SAC_ADDR_COUNTS: begin
            next_rdata = {missCount, matchCount};
         end
         default: begin
            next_rdata = '0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= '0;
      end else if (apbSetup) begin
         prdata <= next_rdata;
      end
   end

endmodule
